//--- common/jtag_prog_pkg.sv
// Constants, state codes and decode helpers for the programming test port.
// Assumes the port logic runs on the test clock and the flash side on the system clock.
package jtag_prog_pkg;

	localparam int IR_WIDTH = 4;
	localparam logic [3:0] OP_CORE_RESET = 4'hc;
	localparam logic [3:0] OP_UNLOCK = 4'h4;
	localparam logic [3:0] OP_COMMAND = 4'h5;
	localparam logic [3:0] OP_PAGE_LOAD = 4'h6;
	localparam logic [3:0] OP_BYPASS = 4'hf;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam logic [3:0] IR_RESET = OP_BYPASS;

	localparam int UNLOCK_WIDTH = 16;
	localparam logic [15:0] UNLOCK_SIGNATURE = 16'ha370;
	localparam logic [15:0] UNLOCK_RESET = 16'h0000;

	localparam int CMD_WIDTH = 15;
	localparam logic [14:0] CMD_RESET = 15'h0000;
	localparam int PAGE_WIDTH = 8;
	localparam int PAGE_ENTRY_WIDTH = 9;
	localparam int PAGE_FIFO_DEPTH = 32;
	localparam int PAGE_WRITE_TCK_CYCLES = 11;

	typedef enum logic [15:0] {
		TLR = 16'h0001,
		RTI = 16'h0002,
		SEL_DR = 16'h0004,
		CAP_DR = 16'h0008,
		SHIFT_DR = 16'h0010,
		EXIT1_DR = 16'h0020,
		PAUSE_DR = 16'h0040,
		EXIT2_DR = 16'h0080,
		UPD_DR = 16'h0100,
		SEL_IR = 16'h0200,
		CAP_IR = 16'h0400,
		SHIFT_IR = 16'h0800,
		EXIT1_IR = 16'h1000,
		PAUSE_IR = 16'h2000,
		EXIT2_IR = 16'h4000,
		UPD_IR = 16'h8000
	} tap_state_type;

	function automatic tap_state_type tap_next(input tap_state_type s, input logic tms);
		tap_state_type n;
		n = TLR;
		case (s)
			TLR: n = tms ? TLR : RTI;
			RTI: n = tms ? SEL_DR : RTI;
			SEL_DR: n = tms ? SEL_IR : CAP_DR;
			CAP_DR: n = tms ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR: n = tms ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: n = tms ? UPD_DR : PAUSE_DR;
			PAUSE_DR: n = tms ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: n = tms ? UPD_DR : SHIFT_DR;
			UPD_DR: n = tms ? SEL_DR : RTI;
			SEL_IR: n = tms ? TLR : CAP_IR;
			CAP_IR: n = tms ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR: n = tms ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: n = tms ? UPD_IR : PAUSE_IR;
			PAUSE_IR: n = tms ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR: n = tms ? UPD_IR : SHIFT_IR;
			UPD_IR: n = tms ? SEL_DR : RTI;
			default: n = TLR;
		endcase
		return n;
	endfunction

	function automatic logic instr_is(input logic [3:0] ir, input logic [3:0] op);
		return ir == op;
	endfunction

endpackage

//--- rtl/level_sync.sv
// Two flip-flop synchroniser for a vector of slow levels or toggles.
// Assumes each bit changes at most once per several destination clocks.
`timescale 1ns/100ps
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_level,
	output logic [WIDTH-1:0] o_level
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] level_d;

	always_comb begin
		meta_d = i_level;
		level_d = meta_q;
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= '0;
			o_level <= '0;
		end else begin
			meta_q <= meta_d;
			o_level <= level_d;
		end
	end
endmodule

//--- rtl/byte_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
// Assumes one clock for both sides; full and empty come from a fill count.
`timescale 1ns/100ps
module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [PW:0] count_q, count_d;
	logic push, pop;

	always_comb begin
		o_in_ready = count_q != (PW+1)'(DEPTH);
		o_out_valid = count_q != '0;
		o_out_data = mem_q[rd_q];
		push = i_in_valid && o_in_ready;
		pop = o_out_valid && i_out_ready;
		wr_d = push ? PW'(wr_q + 1'b1) : wr_q;
		rd_d = pop ? PW'(rd_q + 1'b1) : rd_q;
		count_d = count_q;
		if (push && !pop) begin
			count_d = (PW+1)'(count_q + 1'b1);
		end else if (pop && !push) begin
			count_d = (PW+1)'(count_q - 1'b1);
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			count_q <= count_d;
		end
	end

	// Storage needs no reset; it is only read when the count says it holds data
	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end
endmodule

//--- rtl/tap_prog_top.sv
// Test access port decoding the flash programming instructions.
// Assumes the programmer clocks i_tck; flash side sits on i_clock.
// How it works
// [R01] Opcode 0xC selects one-bit reset chain
// [R02] Core reset instruction leaves TAP running
// [R03] Core held reset while chain holds one
// [R04] Chain drives core reset with no latch
// [R05] Chain shifts one bit per TCK
// [R06] Opcode 0x4 selects 16-bit unlock register
// [R07] Programmer shifts signature in during Shift-DR
// [R08] Update-DR compares signature, enters programming mode
// [R09] Opcode 0x5 selects 15-bit command register
// [R10] Capture-DR loads previous command result
// [R11] Shift-DR outputs result, takes new command
// [R12] Update-DR applies command word to flash
// [R13] Entering Run-Test/Idle executes one command cycle
// [R14] Opcode 0x6 selects low command byte
// [R15] Page byte reaches page buffer quickly
// [R16] Signature fixed; unlock register resets to zero
// [R17] Instruction register four bits wide
// [R18] All shift registers move LSB first
// [R19] Standard sixteen-state TAP, IR at Update-IR
`timescale 1ns/100ps
module tap_prog_top (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	output logic o_tdo,
	output logic o_tdo_oe_n,
	output logic o_core_reset,
	output logic o_prog_mode,
	output logic [jtag_prog_pkg::CMD_WIDTH-1:0] o_cmd_word,
	output logic o_cmd_apply,
	output logic o_cmd_exec,
	input wire logic [jtag_prog_pkg::CMD_WIDTH-1:0] i_cmd_result,
	output logic [jtag_prog_pkg::PAGE_WIDTH-1:0] o_page_byte,
	output logic o_page_high,
	output logic o_page_valid,
	input wire logic i_page_ready
);
	import jtag_prog_pkg::*;

	// Link side, clocked by i_tck
	tap_state_type state_q, state_d;
	logic [IR_WIDTH-1:0] ir_shift_q, ir_shift_d, ir_q, ir_d;
	logic rst_chain_q, rst_chain_d;
	logic [UNLOCK_WIDTH-1:0] unlock_q, unlock_d;
	logic [CMD_WIDTH-1:0] cmd_shift_q, cmd_shift_d, applied_q, applied_d;
	logic bypass_q, bypass_d;
	logic prog_mode_q, prog_mode_d;
	logic apply_tgl_q, apply_tgl_d, exec_tgl_q, exec_tgl_d;
	logic page_req_q, page_req_d, page_high_q, page_high_d;
	logic [PAGE_ENTRY_WIDTH-1:0] page_entry_q, page_entry_d;
	logic tdo_q, tdo_d, tdo_oe_n_q, tdo_oe_n_d;
	logic [CMD_WIDTH:0] back_s;
	logic page_pending;
	logic is_core, is_unlock, is_cmd, is_page;

	// System side, clocked by i_clock
	logic [3:0] fwd_s;
	logic apply_seen_q, apply_seen_d, exec_seen_q, exec_seen_d;
	logic page_ack_q, page_ack_d;
	logic [CMD_WIDTH-1:0] cmd_word_d, result_q;
	logic cmd_apply_d, cmd_exec_d;
	logic fifo_in_valid, fifo_in_ready;
	logic [PAGE_ENTRY_WIDTH-1:0] fifo_out;

	always_comb begin
		is_core = instr_is(ir_q, OP_CORE_RESET);
		is_unlock = instr_is(ir_q, OP_UNLOCK);
		is_cmd = instr_is(ir_q, OP_COMMAND);
		is_page = instr_is(ir_q, OP_PAGE_LOAD);
		page_pending = page_req_q != back_s[0];
		state_d = tap_next(state_q, i_tms); // [R19]
		ir_shift_d = ir_shift_q;
		ir_d = ir_q;
		rst_chain_d = rst_chain_q;
		unlock_d = unlock_q;
		cmd_shift_d = cmd_shift_q;
		applied_d = applied_q;
		bypass_d = bypass_q;
		prog_mode_d = prog_mode_q;
		apply_tgl_d = apply_tgl_q;
		exec_tgl_d = exec_tgl_q;
		page_req_d = page_req_q;
		page_high_d = page_high_q;
		page_entry_d = page_entry_q;
		case (state_q)
			TLR: begin
				ir_d = IR_RESET; // [R19]
			end
			CAP_IR: begin
				ir_shift_d = IR_CAPTURE;
			end
			SHIFT_IR: begin
				ir_shift_d = {i_tdi, ir_shift_q[IR_WIDTH-1:1]}; // [R17] [R18]
			end
			UPD_IR: begin
				ir_d = ir_shift_q; // [R19]
				// Byte order restarts at the low byte on each entry to page load
				if (ir_shift_q == OP_PAGE_LOAD) begin
					page_high_d = 1'b0;
				end
			end
			CAP_DR: begin
				bypass_d = 1'b0;
				if (is_cmd) begin
					cmd_shift_d = back_s[CMD_WIDTH:1]; // [R10]
				end
			end
			SHIFT_DR: begin
				if (is_core) begin
					rst_chain_d = i_tdi; // [R01] [R05]
				end else if (is_unlock) begin
					unlock_d = {i_tdi, unlock_q[UNLOCK_WIDTH-1:1]}; // [R06] [R07] [R18]
				end else if (is_cmd) begin
					cmd_shift_d = {i_tdi, cmd_shift_q[CMD_WIDTH-1:1]}; // [R09] [R11]
				end else if (is_page) begin
					cmd_shift_d[PAGE_WIDTH-1:0] = {i_tdi, cmd_shift_q[PAGE_WIDTH-1:1]}; // [R14]
				end else begin
					bypass_d = i_tdi;
				end
			end
			UPD_DR: begin
				if (is_unlock) begin
					prog_mode_d = unlock_q == UNLOCK_SIGNATURE; // [R08] [R16]
				end else if (is_cmd && prog_mode_q) begin
					applied_d = cmd_shift_q; // [R12]
					apply_tgl_d = !apply_tgl_q;
					if (!i_tms) begin
						exec_tgl_d = !exec_tgl_q; // [R13]
					end
				end else if (is_page && prog_mode_q && !page_pending) begin
					// A byte offered while the previous one is still in flight is dropped
					page_entry_d = {page_high_q, cmd_shift_q[PAGE_WIDTH-1:0]}; // [R15]
					page_req_d = !page_req_q;
					page_high_d = !page_high_q;
				end
			end
			default: begin
			end
		endcase
	end

	// Test-logic-reset reloads only the instruction; core reset stays under chain control
	always_ff @(posedge i_tck or posedge i_rst) begin
		if (i_rst) begin
			state_q <= TLR;
			ir_shift_q <= IR_RESET;
			ir_q <= IR_RESET;
			rst_chain_q <= 1'b0;
			unlock_q <= UNLOCK_RESET; // [R16]
			cmd_shift_q <= CMD_RESET;
			applied_q <= CMD_RESET;
			bypass_q <= 1'b0;
			prog_mode_q <= 1'b0;
			apply_tgl_q <= 1'b0;
			exec_tgl_q <= 1'b0;
			page_req_q <= 1'b0;
			page_high_q <= 1'b0;
			page_entry_q <= '0;
		end else begin
			state_q <= state_d;
			ir_shift_q <= ir_shift_d;
			ir_q <= ir_d;
			rst_chain_q <= rst_chain_d;
			unlock_q <= unlock_d;
			cmd_shift_q <= cmd_shift_d;
			applied_q <= applied_d;
			bypass_q <= bypass_d;
			prog_mode_q <= prog_mode_d;
			apply_tgl_q <= apply_tgl_d;
			exec_tgl_q <= exec_tgl_d;
			page_req_q <= page_req_d;
			page_high_q <= page_high_d;
			page_entry_q <= page_entry_d;
		end
	end

	always_comb begin
		tdo_oe_n_d = !(state_q == SHIFT_IR || state_q == SHIFT_DR);
		tdo_d = bypass_q;
		if (state_q == SHIFT_IR) begin
			tdo_d = ir_shift_q[0]; // [R18]
		end else if (is_core) begin
			tdo_d = rst_chain_q;
		end else if (is_unlock) begin
			tdo_d = unlock_q[0];
		end else if (is_cmd || is_page) begin
			tdo_d = cmd_shift_q[0]; // [R11]
		end
	end

	// Falling edge gives the programmer half a period of setup before its sample
	always_ff @(negedge i_tck or posedge i_rst) begin
		if (i_rst) begin
			tdo_q <= 1'b0;
			tdo_oe_n_q <= 1'b1;
		end else begin
			tdo_q <= tdo_d;
			tdo_oe_n_q <= tdo_oe_n_d;
		end
	end

	assign o_tdo = tdo_q;
	assign o_tdo_oe_n = tdo_oe_n_q;
	// Straight from the chain flop so shifting a zero in releases the core at once
	assign o_core_reset = rst_chain_q; // [R02] [R03] [R04]

	level_sync #(.WIDTH(4)) fwd_sync (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_level({prog_mode_q, page_req_q, exec_tgl_q, apply_tgl_q}),
		.o_level(fwd_s)
	);

	// Result bits are quasi-static between commands, so per-bit sync is enough
	level_sync #(.WIDTH(CMD_WIDTH + 1)) back_sync (
		.i_clock(i_tck),
		.i_rst(i_rst),
		.i_level({result_q, page_ack_q}),
		.o_level(back_s)
	);

	always_comb begin
		apply_seen_d = fwd_s[0];
		exec_seen_d = fwd_s[1];
		cmd_apply_d = fwd_s[0] != apply_seen_q;
		cmd_exec_d = fwd_s[1] != exec_seen_q; // [R13]
		// Word was stable for two clocks before its toggle arrived
		cmd_word_d = cmd_apply_d ? applied_q : o_cmd_word; // [R12]
		fifo_in_valid = fwd_s[2] != page_ack_q;
		page_ack_d = (fifo_in_valid && fifo_in_ready) ? fwd_s[2] : page_ack_q; // [R15]
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			apply_seen_q <= 1'b0;
			exec_seen_q <= 1'b0;
			page_ack_q <= 1'b0;
			o_cmd_word <= CMD_RESET;
			o_cmd_apply <= 1'b0;
			o_cmd_exec <= 1'b0;
			result_q <= CMD_RESET;
		end else begin
			apply_seen_q <= apply_seen_d;
			exec_seen_q <= exec_seen_d;
			page_ack_q <= page_ack_d;
			o_cmd_word <= cmd_word_d;
			o_cmd_apply <= cmd_apply_d;
			o_cmd_exec <= cmd_exec_d;
			result_q <= i_cmd_result;
		end
	end

	assign o_prog_mode = fwd_s[3];

	byte_fifo #(.WIDTH(PAGE_ENTRY_WIDTH), .DEPTH(PAGE_FIFO_DEPTH)) page_fifo (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_in_valid(fifo_in_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data(page_entry_q),
		.o_out_valid(o_page_valid),
		.i_out_ready(i_page_ready),
		.o_out_data(fifo_out)
	);

	assign o_page_byte = fifo_out[PAGE_WIDTH-1:0];
	assign o_page_high = fifo_out[PAGE_WIDTH];

	chain_shift_a: assert property (@(posedge i_tck) disable iff (i_rst) // [R05]
		(state_q == SHIFT_DR && is_core) |=> o_core_reset == $past(i_tdi))
		else $error("reset chain did not take TDI");
	core_keep_a: assert property (@(posedge i_tck) disable iff (i_rst) // [R02]
		(o_core_reset && state_q != TLR && state_q != UPD_IR) |=> ir_q == $past(ir_q))
		else $error("core reset disturbed the instruction");
	unlock_match_a: assert property (@(posedge i_tck) disable iff (i_rst) // [R08]
		(state_q == UPD_DR && is_unlock && unlock_q == UNLOCK_SIGNATURE) |=> prog_mode_q)
		else $error("valid signature did not unlock");
	unlock_miss_a: assert property (@(posedge i_tck) disable iff (i_rst) // [R16]
		(state_q == UPD_DR && is_unlock && unlock_q != UNLOCK_SIGNATURE) |=> !prog_mode_q)
		else $error("wrong signature unlocked");
	result_capture_a: assert property (@(posedge i_tck) disable iff (i_rst) // [R10]
		(state_q == CAP_DR && is_cmd) |=> cmd_shift_q == $past(back_s[CMD_WIDTH:1]))
		else $error("result not captured");
	cmd_shift_a: assert property (@(posedge i_tck) disable iff (i_rst) // [R11]
		(state_q == SHIFT_DR && is_cmd) |=> cmd_shift_q[CMD_WIDTH-1] == $past(i_tdi)
		&& cmd_shift_q[CMD_WIDTH-2:0] == $past(cmd_shift_q[CMD_WIDTH-1:1]))
		else $error("command register shifted wrongly");
	ir_update_a: assert property (@(posedge i_tck) disable iff (i_rst) // [R19]
		state_q == UPD_IR |=> ir_q == $past(ir_shift_q))
		else $error("instruction not updated");
	tms_reset_a: assert property (@(posedge i_tck) disable iff (i_rst) // [R19]
		i_tms [*5] |=> state_q == TLR)
		else $error("five TMS ones did not reach reset");
	apply_path_a: assert property (@(posedge i_tck) disable iff (i_rst) // [R12]
		(state_q == UPD_DR && is_cmd && prog_mode_q) |=> applied_q == $past(cmd_shift_q)
		##[2:8] o_cmd_word == applied_q)
		else $error("command word not applied");
	exec_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst) // [R13]
		o_cmd_exec |=> !o_cmd_exec)
		else $error("execute pulse longer than one cycle");
	page_push_a: assert property (@(posedge i_clock) disable iff (i_rst) // [R15]
		(fifo_in_valid && fifo_in_ready) |=> o_page_valid && page_ack_q == fwd_s[2])
		else $error("page byte not pushed");

	unlock_c: cover property (@(posedge i_tck) disable iff (i_rst) $rose(prog_mode_q));
	exec_c: cover property (@(posedge i_clock) disable iff (i_rst) o_cmd_exec);
	page_c: cover property (@(posedge i_clock) disable iff (i_rst) o_page_valid && o_page_high);
	core_reset_c: cover property (@(posedge i_tck) disable iff (i_rst) $fell(o_core_reset));
endmodule

//--- test/jtag_programmer.sv
// Model of the external programmer driving the test access port.
// Assumes one bench process calls its tasks; the test clock stops between frames.
`timescale 1ns/100ps
module jtag_programmer (
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	input wire logic i_tdo
);
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b1;
	end
	// One test clock period; TDO is taken at the rising edge, never after release
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		o_tms = tms;
		o_tdi = tdi;
		#7.5 o_tck = 1'b1;
		tdo = i_tdo;
		#7.5 o_tck = 1'b0;
	endtask
	// Starts and ends in Run-Test/Idle; ir selects the instruction path
	task automatic scan(input logic ir, input int n, input logic [15:0] din,
		output logic [15:0] dout);
		logic t;
		dout = '0;
		step(1'b1, 1'b1, t);
		if (ir) begin
			step(1'b1, 1'b1, t);
		end
		step(1'b0, 1'b1, t);
		step(1'b0, 1'b1, t);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], t);
			dout[i] = t;
		end
		step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
	endtask
	// Five ones reach Test-Logic-Reset from anywhere; ends in Run-Test/Idle
	task automatic reset_tap();
		logic t;
		repeat (5) step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
	endtask
	task automatic idle(input int n);
		logic t;
		repeat (n) step(1'b0, 1'b1, t);
	endtask
endmodule

//--- test/tb_top.sv
// Self-checking bench for the programming test port.
// Assumes the programmer model drives the test pins; TDO is pulled up when released.
`timescale 1ns/100ps
module tb_top;
	import jtag_prog_pkg::*;
	logic i_clock, i_rst, tck, tms, tdi, tdo_line, i_page_ready;
	logic o_tdo, o_tdo_oe_n, o_core_reset, o_prog_mode, o_cmd_apply, o_cmd_exec;
	logic o_page_high, o_page_valid;
	logic [CMD_WIDTH-1:0] o_cmd_word, i_cmd_result, last_word;
	logic [PAGE_WIDTH-1:0] o_page_byte;
	int fail_count, checks_done, apply_count, exec_count, n;
	logic [31:0] seed;
	logic [15:0] dout, cmd;
	logic [8:0] sunk[$];
	logic [8:0] want[$];

	tap_prog_top i_tap_prog_top (.i_clock(i_clock), .i_rst(i_rst), .i_tck(tck), .i_tms(tms),
		.i_tdi(tdi), .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .o_core_reset(o_core_reset),
		.o_prog_mode(o_prog_mode), .o_cmd_word(o_cmd_word), .o_cmd_apply(o_cmd_apply),
		.o_cmd_exec(o_cmd_exec), .i_cmd_result(i_cmd_result), .o_page_byte(o_page_byte),
		.o_page_high(o_page_high), .o_page_valid(o_page_valid), .i_page_ready(i_page_ready));
	jtag_programmer i_jtag_programmer (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
		.i_tdo(tdo_line));
	assign tdo_line = o_tdo_oe_n ? 1'b1 : o_tdo;

	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Page bytes alternate low then high after each instruction load
	function automatic logic [8:0] entry(input int k, input logic [7:0] b);
		return {k[0], b};
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (fail_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	always @(posedge i_clock) begin
		if (o_cmd_apply === 1'b1) begin
			apply_count++;
			last_word = o_cmd_word;
		end
		if (o_cmd_exec === 1'b1) begin
			exec_count++;
		end
		if (o_page_valid === 1'b1 && i_page_ready === 1'b1) begin
			sunk.push_back({o_page_high, o_page_byte});
		end
	end

	initial begin
		#100000;
		fail_count++;
		close_out();
	end

	initial begin
		seed = 32'h369a;
		i_rst = 1'b1;
		i_cmd_result = '0;
		i_page_ready = 1'b0;
		fail_count = 0;
		checks_done = 0;
		apply_count = 0;
		exec_count = 0;
		repeat (8) @(posedge i_clock);
		#1 i_rst = 1'b0;
		check(o_core_reset, 1'b0);
		check(o_tdo_oe_n, 1'b1);
		check(o_prog_mode, 1'b0);
		i_jtag_programmer.idle(1);
		i_jtag_programmer.scan(1'b1, IR_WIDTH, OP_CORE_RESET, dout);
		check(dout, IR_CAPTURE);
		i_jtag_programmer.scan(1'b0, 1, 16'h0001, dout);
		check(o_core_reset, 1'b1);
		check(dout, 16'h0000);
		// Port must keep working while the core sits in reset
		i_jtag_programmer.scan(1'b1, IR_WIDTH, OP_COMMAND, dout);
		check(dout, IR_CAPTURE);
		i_jtag_programmer.scan(1'b0, CMD_WIDTH, 16'h1234, dout);
		i_jtag_programmer.idle(8);
		check(16'(apply_count), 16'h0000);
		i_jtag_programmer.scan(1'b1, IR_WIDTH, OP_CORE_RESET, dout);
		i_jtag_programmer.scan(1'b0, 1, 16'h0000, dout);
		check(dout, 16'h0001);
		check(o_core_reset, 1'b0);
		i_jtag_programmer.scan(1'b1, IR_WIDTH, OP_UNLOCK, dout);
		seed = lfsr(seed);
		i_jtag_programmer.scan(1'b0, UNLOCK_WIDTH, seed[15:0] | 16'h0001, dout);
		repeat (10) @(posedge i_clock);
		check(o_prog_mode, 1'b0);
		i_jtag_programmer.scan(1'b0, UNLOCK_WIDTH, UNLOCK_SIGNATURE, dout);
		for (n = 0; n < 30 && o_prog_mode !== 1'b1; n++) @(posedge i_clock);
		check(o_prog_mode, 1'b1);
		// Five TMS ones return to bypass but keep programming mode
		i_jtag_programmer.reset_tap();
		i_jtag_programmer.scan(1'b0, 2, 16'h0001, dout);
		check(dout, 16'h0002);
		check(o_prog_mode, 1'b1);
		i_jtag_programmer.scan(1'b1, IR_WIDTH, OP_COMMAND, dout);
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			@(posedge i_clock);
			#1 i_cmd_result = seed[30:16];
			// Result crosses bit by bit, so it must settle before the capture
			repeat (2) @(posedge i_clock);
			#1;
			cmd = (k == 0) ? 16'h7fff : {1'b0, seed[14:0]};
			i_jtag_programmer.scan(1'b0, CMD_WIDTH, cmd, dout);
			check(dout, {1'b0, i_cmd_result});
			for (n = 0; n < 40 && exec_count <= k; n++) @(posedge i_clock);
			check(16'(exec_count), 16'(k + 1));
			check(16'(apply_count), 16'(exec_count));
			check({1'b0, last_word}, cmd);
		end
		i_jtag_programmer.scan(1'b1, IR_WIDTH, OP_PAGE_LOAD, dout);
		// Sink stalls while one byte more than the buffer holds is sent
		for (int k = 0; k <= PAGE_FIFO_DEPTH; k++) begin
			seed = lfsr(seed);
			i_jtag_programmer.scan(1'b0, PAGE_WIDTH, {8'h00, seed[7:0]}, dout);
			// The extra byte waits in the crossing until the sink frees a slot
			want.push_back(entry(k, seed[7:0]));
			i_jtag_programmer.idle((k == 0) ? PAGE_WRITE_TCK_CYCLES : 6);
			if (k == 0) begin
				check(o_page_valid, 1'b1);
			end
		end
		@(posedge i_clock);
		#1 i_page_ready = 1'b1;
		for (n = 0; n < 200 && o_page_valid !== 1'b0; n++) @(posedge i_clock);
		check(o_page_valid, 1'b0);
		check(16'(sunk.size()), 16'(PAGE_FIFO_DEPTH + 1));
		foreach (want[j]) check(sunk[j], want[j]);
		close_out();
	end
endmodule
